/* hw/otgmon_pkg.sv */
// Register map, field positions and reset values of the OTG monitor block
package otgmon_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OTG_CTRL_OFS    = 8'h00;
    localparam logic [7:0] EDGE_RISE_OFS   = 8'h01;
    localparam logic [7:0] EDGE_FALL_OFS   = 8'h02;
    localparam logic [7:0] ID_EDGE_EN_OFS  = 8'h03;
    localparam logic [7:0] USB_STATUS_OFS  = 8'h04;
    localparam logic [7:0] KIT_STATUS_OFS  = 8'h05;
    localparam logic [7:0] RID_CODE_OFS    = 8'h06;
    localparam logic [7:0] EXT_SENSE_OFS   = 8'h07;

    // OTG control fields
    localparam int ID_PULL_BIT   = 0;
    localparam int DRAIN_BIT     = 3;
    localparam int LIFT_BIT      = 4;
    localparam int SUPPLY_BIT    = 5;
    localparam int SUPPLY_X_BIT  = 6;

    // Edge enable and status fields (same layout)
    localparam int VBUS_VALID_BIT = 1;
    localparam int SESS_VALID_BIT = 2;
    localparam int SESS_END_BIT   = 3;
    localparam int ID_GND_BIT     = 4;

    // ID-open enables and status
    localparam int ID_OPEN_RISE_BIT = 0;
    localparam int ID_OPEN_FALL_BIT = 1;
    localparam int ID_OPEN_BIT      = 0;

    // External sense selection fields
    localparam int EXT_SEL_BIT  = 0;
    localparam int EXT_PASS_BIT = 1;
    localparam int EXT_COMP_BIT = 2;

    // Reset values
    localparam logic [7:0] OTG_CTRL_RST   = 8'h00;
    localparam logic [7:0] EDGE_RISE_RST  = 8'h1e;
    localparam logic [7:0] EDGE_FALL_RST  = 8'h1e;
    localparam logic [7:0] ID_EDGE_EN_RST = 8'h00;
    localparam logic [7:0] EXT_SENSE_RST  = 8'h00;

    // External indicator is hard-wired high
    localparam logic EXT_INDICATOR = 1'b1;

    // Comparator vector layout after synchronising
    localparam int CMP_W       = 5;
    localparam int CMP_VBUS    = 0;
    localparam int CMP_SESSV   = 1;
    localparam int CMP_SESSE   = 2;
    localparam int CMP_ID_GROUNDED_FLAG   = 3;
    localparam int CMP_IDOPEN  = 4;
    localparam int RID_W       = 3;
endpackage

/* hw/otgmon_sync.sv */
// Two-flop synchroniser for a vector of slow asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module otgmon_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    stage1_reg[i] <= 1'b0;
                    syncOut[i]    <= 1'b0;
                end else begin
                    stage1_reg[i] <= asyncIn[i];
                    syncOut[i]    <= stage1_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/otgmon_edge.sv */
// Per-bit rising/falling change detector with separate edge enables
`timescale 1ns/10ps
`default_nettype none
module otgmon_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] riseEn,
    input  wire logic [WIDTH-1:0] fallEn,
    output logic      [WIDTH-1:0] changeEvt
);
    logic [WIDTH-1:0] prev_reg;
    logic [2:0]       armed_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

    // Synchroniser depth plus one edge; a level already high at release is no change
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            armed_reg <= 3'h0;
        end else begin
            armed_reg <= {armed_reg[1:0], 1'b1};
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign changeEvt[i] = armed_reg[2] &
                                  ((level[i] & ~prev_reg[i] & riseEn[i]) |
                                   (~level[i] & prev_reg[i] & fallEn[i]));
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/otgmon_ctrl.sv */
// OTG cable-ID and VBUS monitor: registers, status, change events, pad controls
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module otgmon_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    // Analog comparator outputs (asynchronous)
    input  wire logic       vbusValidCmp,
    input  wire logic       sessValidCmp,
    input  wire logic       sessEndCmp,
    input  wire logic       idGroundedCmp,
    input  wire logic       idOpenCmp,
    input  wire logic [2:0] ridCodeIn,
    // Mode from the interface logic, same clock
    input  wire logic       syncMode,
    // Pad and comparator controls
    output logic            idPullEnable,
    output logic            vbusDrainEnable,
    output logic            vbusLiftEnable,
    output logic            supplySwitchOut,
    output logic            sessEndCmpOn,
    output logic            vbusValidCmpOn,
    // Receive command request to the interface logic
    output logic            rxCmdValid,
    output logic            rxCmdAltInt,
    output logic            rxCmdVbusValid,
    output logic            rxCmdSessValid,
    output logic            rxCmdSessEnd,
    output logic            rxCmdIdGrounded
);
    logic [7:0] otgCtrl_reg;
    logic [7:0] edgeRise_reg;
    logic [7:0] edgeFall_reg;
    logic [7:0] idEdgeEn_reg;
    logic [7:0] extSense_reg;
    logic [7:0] rdData_next;

    logic [otgmon_pkg::CMP_W-1:0] cmpSync;
    logic [otgmon_pkg::CMP_W-1:0] cmpLevel;
    logic [otgmon_pkg::CMP_W-1:0] riseVec;
    logic [otgmon_pkg::CMP_W-1:0] fallVec;
    logic [otgmon_pkg::CMP_W-1:0] cmpEvt;
    logic [otgmon_pkg::RID_W-1:0] ridSync;
    logic                         vbusValidSrc;

    // Comparators are unclocked analog levels
    otgmon_sync #(
        .WIDTH (otgmon_pkg::CMP_W)
    ) u_cmp_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({idOpenCmp, idGroundedCmp, sessEndCmp, sessValidCmp, vbusValidCmp}),
        .syncOut (cmpSync)
    );

    // Converter code only read by software, so per-bit skew is harmless
    otgmon_sync #(
        .WIDTH (otgmon_pkg::RID_W)
    ) u_rid_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (ridCodeIn),
        .syncOut (ridSync)
    );

    // Register writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            otgCtrl_reg <= otgmon_pkg::OTG_CTRL_RST;
        end else if (regWrEn && regAddr == otgmon_pkg::OTG_CTRL_OFS) begin
            otgCtrl_reg <= regWrData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edgeRise_reg <= otgmon_pkg::EDGE_RISE_RST;
            edgeFall_reg <= otgmon_pkg::EDGE_FALL_RST;
            idEdgeEn_reg <= otgmon_pkg::ID_EDGE_EN_RST;
        end else if (regWrEn) begin
            if (regAddr == otgmon_pkg::EDGE_RISE_OFS) begin
                edgeRise_reg <= regWrData;
            end
            if (regAddr == otgmon_pkg::EDGE_FALL_OFS) begin
                edgeFall_reg <= regWrData;
            end
            if (regAddr == otgmon_pkg::ID_EDGE_EN_OFS) begin
                idEdgeEn_reg <= regWrData;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            extSense_reg <= otgmon_pkg::EXT_SENSE_RST;
        end else if (regWrEn && regAddr == otgmon_pkg::EXT_SENSE_OFS) begin
            extSense_reg <= regWrData;
        end
    end

    // Pad controls
    assign idPullEnable    = otgCtrl_reg[otgmon_pkg::ID_PULL_BIT];
    assign vbusDrainEnable = otgCtrl_reg[otgmon_pkg::DRAIN_BIT];
    assign vbusLiftEnable  = otgCtrl_reg[otgmon_pkg::LIFT_BIT];
    assign supplySwitchOut = otgCtrl_reg[otgmon_pkg::SUPPLY_BIT] |
                             otgCtrl_reg[otgmon_pkg::SUPPLY_X_BIT];

    // The session-end and VBUS-valid comparators are powered while either edge enable holds them
    assign sessEndCmpOn   = edgeRise_reg[otgmon_pkg::SESS_END_BIT] |
                            edgeFall_reg[otgmon_pkg::SESS_END_BIT];
    assign vbusValidCmpOn = edgeRise_reg[otgmon_pkg::VBUS_VALID_BIT] |
                            edgeFall_reg[otgmon_pkg::VBUS_VALID_BIT];

    // Gated levels; a switched-off comparator reads as 0
    always_comb begin
        cmpLevel = cmpSync;
        cmpLevel[otgmon_pkg::CMP_SESSE] = cmpSync[otgmon_pkg::CMP_SESSE] & sessEndCmpOn;
        cmpLevel[otgmon_pkg::CMP_VBUS]  = cmpSync[otgmon_pkg::CMP_VBUS] & vbusValidCmpOn;
    end

    // Session-valid stays powered; its enables only gate events
    always_comb begin
        riseVec = '0;
        fallVec = '0;
        riseVec[otgmon_pkg::CMP_VBUS]   = edgeRise_reg[otgmon_pkg::VBUS_VALID_BIT];
        fallVec[otgmon_pkg::CMP_VBUS]   = edgeFall_reg[otgmon_pkg::VBUS_VALID_BIT];
        riseVec[otgmon_pkg::CMP_SESSV]  = edgeRise_reg[otgmon_pkg::SESS_VALID_BIT];
        fallVec[otgmon_pkg::CMP_SESSV]  = edgeFall_reg[otgmon_pkg::SESS_VALID_BIT];
        riseVec[otgmon_pkg::CMP_SESSE]  = edgeRise_reg[otgmon_pkg::SESS_END_BIT];
        fallVec[otgmon_pkg::CMP_SESSE]  = edgeFall_reg[otgmon_pkg::SESS_END_BIT];
        riseVec[otgmon_pkg::CMP_ID_GROUNDED_FLAG]  = edgeRise_reg[otgmon_pkg::ID_GND_BIT];
        fallVec[otgmon_pkg::CMP_ID_GROUNDED_FLAG]  = edgeFall_reg[otgmon_pkg::ID_GND_BIT];
        riseVec[otgmon_pkg::CMP_IDOPEN] = idEdgeEn_reg[otgmon_pkg::ID_OPEN_RISE_BIT];
        fallVec[otgmon_pkg::CMP_IDOPEN] = idEdgeEn_reg[otgmon_pkg::ID_OPEN_FALL_BIT];
    end

    otgmon_edge #(
        .WIDTH (otgmon_pkg::CMP_W)
    ) u_edge (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .level     (cmpLevel),
        .riseEn    (riseVec),
        .fallEn    (fallVec),
        .changeEvt (cmpEvt)
    );

    // Receive-command VBUS-valid source
    always_comb begin
        if (!extSense_reg[otgmon_pkg::EXT_SEL_BIT]) begin
            vbusValidSrc = cmpLevel[otgmon_pkg::CMP_VBUS];
        end else if (extSense_reg[otgmon_pkg::EXT_PASS_BIT]) begin
            vbusValidSrc = otgmon_pkg::EXT_INDICATOR ^ extSense_reg[otgmon_pkg::EXT_COMP_BIT];
        end else begin
            vbusValidSrc = cmpLevel[otgmon_pkg::CMP_VBUS] &
                           (otgmon_pkg::EXT_INDICATOR ^ extSense_reg[otgmon_pkg::EXT_COMP_BIT]);
        end
    end

    // One request per cycle with any enabled change; ID-open takes the alternate-interrupt flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxCmdValid  <= 1'b0;
            rxCmdAltInt <= 1'b0;
        end else begin
            rxCmdValid  <= |cmpEvt;
            rxCmdAltInt <= cmpEvt[otgmon_pkg::CMP_IDOPEN];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxCmdVbusValid  <= 1'b0;
            rxCmdSessValid  <= 1'b0;
            rxCmdSessEnd    <= 1'b0;
            rxCmdIdGrounded <= 1'b0;
        end else begin
            rxCmdVbusValid  <= vbusValidSrc;
            rxCmdSessValid  <= cmpLevel[otgmon_pkg::CMP_SESSV];
            rxCmdSessEnd    <= cmpLevel[otgmon_pkg::CMP_SESSE];
            rxCmdIdGrounded <= cmpLevel[otgmon_pkg::CMP_ID_GROUNDED_FLAG];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdData_next = 8'h00;
        case (regAddr)
            otgmon_pkg::OTG_CTRL_OFS:   rdData_next = otgCtrl_reg;
            otgmon_pkg::EDGE_RISE_OFS:  rdData_next = edgeRise_reg;
            otgmon_pkg::EDGE_FALL_OFS:  rdData_next = edgeFall_reg;
            otgmon_pkg::ID_EDGE_EN_OFS: rdData_next = idEdgeEn_reg;
            otgmon_pkg::USB_STATUS_OFS: begin
                rdData_next[otgmon_pkg::VBUS_VALID_BIT] = cmpLevel[otgmon_pkg::CMP_VBUS];
                rdData_next[otgmon_pkg::SESS_VALID_BIT] = cmpLevel[otgmon_pkg::CMP_SESSV];
                rdData_next[otgmon_pkg::SESS_END_BIT]   = cmpLevel[otgmon_pkg::CMP_SESSE];
                rdData_next[otgmon_pkg::ID_GND_BIT]     = cmpLevel[otgmon_pkg::CMP_ID_GROUNDED_FLAG];
            end
            otgmon_pkg::KIT_STATUS_OFS: begin
                rdData_next[otgmon_pkg::ID_OPEN_BIT] = cmpLevel[otgmon_pkg::CMP_IDOPEN];
            end
            otgmon_pkg::RID_CODE_OFS: begin
                // Converter only runs in synchronous mode
                if (syncMode) begin
                    rdData_next[otgmon_pkg::RID_W-1:0] = ridSync;
                end
            end
            otgmon_pkg::EXT_SENSE_OFS:  rdData_next = extSense_reg;
            default:                    rdData_next = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= rdData_next;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ---------------- assertions ----------------
    sequence s_ctrlWrite(int b);
        regWrEn && regAddr == otgmon_pkg::OTG_CTRL_OFS && regWrData[b];
    endsequence

    property p_supplyOn;
        @(posedge ref_clk) disable iff (rst)
        s_ctrlWrite(otgmon_pkg::SUPPLY_X_BIT) |=> supplySwitchOut;
    endproperty
    a_supplyOn: assert property (p_supplyOn) else $error("supply switch not driven");

    property p_resetLow;
        @(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> !supplySwitchOut && !vbusDrainEnable && !vbusLiftEnable;
    endproperty
    a_resetLow: assert property (p_resetLow) else $error("controls not clear at reset");

    property p_drain;
        @(posedge ref_clk) disable iff (rst)
        s_ctrlWrite(otgmon_pkg::DRAIN_BIT) |=> vbusDrainEnable;
    endproperty
    a_drain: assert property (p_drain) else $error("drain not enabled");

    property p_lift;
        @(posedge ref_clk) disable iff (rst)
        regWrEn && regAddr == otgmon_pkg::OTG_CTRL_OFS |=> vbusLiftEnable == $past(regWrData[4]);
    endproperty
    a_lift: assert property (p_lift) else $error("lift enable wrong");

    property p_sessEndOff;
        @(posedge ref_clk) disable iff (rst)
        regRdEn && regAddr == otgmon_pkg::USB_STATUS_OFS && !sessEndCmpOn |=> !regRdData[3];
    endproperty
    a_sessEndOff: assert property (p_sessEndOff) else $error("session end read while off");

    property p_vbusOff;
        @(posedge ref_clk) disable iff (rst)
        regRdEn && regAddr == otgmon_pkg::USB_STATUS_OFS && !vbusValidCmpOn |=> !regRdData[1];
    endproperty
    a_vbusOff: assert property (p_vbusOff) else $error("vbus valid read while off");

    property p_ridMode;
        @(posedge ref_clk) disable iff (rst)
        regRdEn && regAddr == otgmon_pkg::RID_CODE_OFS && !syncMode |=> regRdData == 8'h00;
    endproperty
    a_ridMode: assert property (p_ridMode) else $error("rid code outside sync mode");

    sequence s_idOpenEdge;
        ($rose(cmpLevel[4]) && riseVec[4]) || ($fell(cmpLevel[4]) && fallVec[4]);
    endsequence

    property p_idOpenCmd;
        @(posedge ref_clk) disable iff (rst)
        s_idOpenEdge |=> rxCmdValid && rxCmdAltInt;
    endproperty
    a_idOpenCmd: assert property (p_idOpenCmd) else $error("no alt receive command");

    property p_idGndCmd;
        @(posedge ref_clk) disable iff (rst)
        $fell(cmpLevel[3]) && fallVec[3] |=> rxCmdValid && !rxCmdIdGrounded;
    endproperty
    a_idGndCmd: assert property (p_idGndCmd) else $error("no id grounded event");

    property p_syncDelay;
        @(posedge ref_clk) disable iff (rst)
        $rose(sessValidCmp) ##1 sessValidCmp |-> ##1 cmpSync[1];
    endproperty
    a_syncDelay: assert property (p_syncDelay) else $error("sync latency wrong");

    property p_singleEvt;
        @(posedge ref_clk) disable iff (rst)
        rxCmdValid |=> !rxCmdValid || $past(cmpLevel) != $past(cmpLevel, 2);
    endproperty
    a_singleEvt: assert property (p_singleEvt) else $error("repeated event");

    property p_rxVbusSrc;
        @(posedge ref_clk) disable iff (rst)
        !extSense_reg[0] |=> rxCmdVbusValid == $past(cmpLevel[0]);
    endproperty
    a_rxVbusSrc: assert property (p_rxVbusSrc) else $error("vbus valid source wrong");
endmodule
`default_nettype wire

/* tb/otgmon_cable_model.sv */
// Cable and VBUS environment model feeding the monitor's comparator inputs
`timescale 1ns/10ps
`default_nettype none
module otgmon_cable_model (
    input  wire logic       ref_clk,
    input  wire logic [2:0] cableSel,
    input  wire logic [1:0] vbusLvl,
    output logic            vbusValidCmp,
    output logic            sessValidCmp,
    output logic            sessEndCmp,
    output logic            idGroundedCmp,
    output logic            idOpenCmp,
    output logic      [2:0] ridCodeIn
);
    // Cable codes: 0 gnd, 1 75R, 2 102k, 3 200k, 4 440k, 5 open
    // Supply levels: 0 below session end, 1 session valid, 2 VBUS valid
    always_ff @(posedge ref_clk) begin
        ridCodeIn     <= cableSel;
        idGroundedCmp <= (cableSel >= 3'h2);
        idOpenCmp     <= (cableSel == 3'h5);
        sessEndCmp    <= (vbusLvl == 2'h0);
        sessValidCmp  <= (vbusLvl != 2'h0);
        vbusValidCmp  <= (vbusLvl == 2'h2);
    end
endmodule
`default_nettype wire

/* tb/otgmon_ctrl_tb.sv */
// Self-checking bench for the OTG cable-ID and VBUS monitor
`timescale 1ns/10ps
`default_nettype none
module otgmon_ctrl_tb;
    logic       ref_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] regAddr   = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrEn   = 1'b0;
    logic       regRdEn   = 1'b0;
    logic       syncMode  = 1'b1;
    logic [2:0] cableSel  = 3'h5;
    logic [1:0] vbusLvl   = 2'h2;
    logic [7:0] regRdData;
    logic       vbusValidCmp, sessValidCmp, sessEndCmp, idGroundedCmp, idOpenCmp;
    logic [2:0] ridCodeIn;
    logic       idPullEnable, vbusDrainEnable, vbusLiftEnable, supplySwitchOut;
    logic       sessEndCmpOn, vbusValidCmpOn, rxCmdValid, rxCmdAltInt;
    logic       rxCmdVbusValid, rxCmdSessValid, rxCmdSessEnd, rxCmdIdGrounded;
    logic [7:0] mdl [8];
    logic [7:0] d;
    logic [7:0] extCases [7] = '{8'h00, 8'h02, 8'h06, 8'h01, 8'h03, 8'h05, 8'h07};
    int         num_errors = 0;
    int         compares   = 0;
    int         evCnt      = 0;
    int         altCnt     = 0;

    otgmon_ctrl i_otgmon_ctrl (.ref_clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .vbusValidCmp, .sessValidCmp, .sessEndCmp, .idGroundedCmp, .idOpenCmp,
        .ridCodeIn, .syncMode, .idPullEnable, .vbusDrainEnable, .vbusLiftEnable,
        .supplySwitchOut, .sessEndCmpOn, .vbusValidCmpOn, .rxCmdValid, .rxCmdAltInt,
        .rxCmdVbusValid, .rxCmdSessValid, .rxCmdSessEnd, .rxCmdIdGrounded);

    otgmon_cable_model i_otgmon_cable_model (.ref_clk, .cableSel, .vbusLvl, .vbusValidCmp,
        .sessValidCmp, .sessEndCmp, .idGroundedCmp, .idOpenCmp, .ridCodeIn);

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (rxCmdValid === 1'b1) begin
            evCnt++;
            if (rxCmdAltInt === 1'b1) altCnt++;
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= v;
        regWrEn   <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        mdl[a[2:0]] = v;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 v = regRdData;
    endtask

    function automatic logic [4:0] flags(input logic [2:0] c, input logic [1:0] v);
        flags = {c == 3'h5, c >= 3'h2, v == 2'h0, v != 2'h0, v == 2'h2};
    endfunction

    // Moves cable or supply, then checks events, status words and command levels
    task automatic env(input logic [2:0] c, input logic [1:0] v);
        logic [4:0] o, n, hit;
        logic [7:0] en, s, r;
        logic       vi, ve;
        int         e0, a0;
        o   = flags(cableSel, vbusLvl);
        n   = flags(c, v);
        hit = ({mdl[3][0], mdl[1][4:1]} & n & ~o) | ({mdl[3][1], mdl[2][4:1]} & o & ~n);
        en  = mdl[1] | mdl[2];
        s   = mdl[7];
        e0  = evCnt;
        a0  = altCnt;
        @(posedge ref_clk);
        cableSel <= c;
        vbusLvl  <= v;
        repeat (6) @(posedge ref_clk);
        #1;
        check("events", 8'(evCnt - e0), {7'h0, |hit});
        check("alt events", 8'(altCnt - a0), {7'h0, hit[4]});
        vi = n[0] & en[1];
        ve = !s[0] ? vi : (s[1] ? ~s[2] : vi & ~s[2]);
        check("cmd vbus", {7'h0, rxCmdVbusValid}, {7'h0, ve});
        check("cmd levels", {rxCmdIdGrounded, rxCmdSessEnd, rxCmdSessValid},
              {n[3], n[2] & en[3], n[1]});
        rd(otgmon_pkg::USB_STATUS_OFS, r);
        check("status", r & 8'h1e,
              {3'h0, n[3], n[2] & en[3], n[1], vi, 1'b0});
        rd(otgmon_pkg::KIT_STATUS_OFS, r);
        check("kit status", r & 8'h01, {7'h0, n[4]});
        rd(otgmon_pkg::RID_CODE_OFS, r);
        check("rid", r, {5'h0, syncMode ? c : 3'h0});
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        test_done();
    end

    initial begin
        mdl = '{8'h00, 8'h1e, 8'h1e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(32'h76e136a6));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // Comparators already high at release must not look like a change
        repeat (6) @(posedge ref_clk);
        check("start events", 8'(evCnt), 8'h00);
        for (int a = 0; a < 9; a++) begin
            if (a < 4 || a > 6) begin
                rd(8'(a), d);
                check("reset value", d, (a == 8) ? 8'h00 : mdl[a]);
            end
        end
        check("pins at reset", {supplySwitchOut, sessEndCmpOn, vbusValidCmpOn}, 8'h03);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[6:5] = i[1:0];
            wr(otgmon_pkg::OTG_CTRL_OFS, d);
            check("pad controls", {idPullEnable, vbusDrainEnable, vbusLiftEnable},
                  {d[0], d[3], d[4]});
            check("supply switch", {7'h0, supplySwitchOut}, {7'h0, d[5] | d[6]});
        end
        // Pull-up on before ID reads; analog settling not modelled, so no long wait
        wr(otgmon_pkg::OTG_CTRL_OFS, 8'h01);
        $display("test controls done");
        for (int c = 0; c < 6; c++) env(3'(c), 2'h2);
        @(posedge ref_clk);
        syncMode <= 1'b0;
        env(3'h2, 2'h2);
        @(posedge ref_clk);
        syncMode <= 1'b1;
        $display("test cable done");
        wr(otgmon_pkg::ID_EDGE_EN_OFS, 8'h03);
        env(3'h5, 2'h2);
        env(3'h2, 2'h2);
        env(3'h5, 2'h2);
        // Link saves current after an A plug: enables off, no alt events
        wr(otgmon_pkg::ID_EDGE_EN_OFS, 8'h00);
        wr(otgmon_pkg::OTG_CTRL_OFS, 8'h00);
        env(3'h2, 2'h2);
        $display("test id open done");
        env(3'h2, 2'h0);
        env(3'h2, 2'h1);
        env(3'h2, 2'h2);
        // Every select, pass-through and complement combination except complement alone (8'h04)
        foreach (extCases[m]) begin
            wr(otgmon_pkg::EXT_SENSE_OFS, extCases[m]);
            env(3'h2, 2'h1);
            env(3'h2, 2'h2);
        end
        wr(otgmon_pkg::EXT_SENSE_OFS, 8'h00);
        $display("test vbus source done");
        wr(otgmon_pkg::EDGE_RISE_OFS, 8'h10);
        wr(otgmon_pkg::EDGE_FALL_OFS, 8'h10);
        repeat (6) @(posedge ref_clk);
        check("cmp on", {sessEndCmpOn, vbusValidCmpOn}, 8'h00);
        env(3'h2, 2'h0);
        env(3'h2, 2'h2);
        env(3'h0, 2'h1);
        $display("test comparator off done");
        test_done();
    end
endmodule
`default_nettype wire
